//--- inc/flmc_pkg.sv
// flmc_pkg: constants shared by the nonvolatile memory controller core.
// assumes one bus clock; global byte addresses are 24 bits wide.
package flmc_pkg;

    // address map
    localparam int          ADDR_W      = 24;
    localparam int          PF_AW       = 17;
    localparam int          EE_AW       = 9;
    localparam logic [6:0]  PF_TAG      = 7'h7f;
    localparam logic [14:0] EE_TAG      = 15'h0800;
    localparam int          PF_BYTES    = 131072;
    localparam int          EE_BYTES    = 512;

    // ecc geometry: program array by half-phrase, eeprom by 16-bit word
    localparam int          PF_DW       = 32;
    localparam int          PF_HB       = 6;
    localparam int          PF_CW       = PF_DW + PF_HB + 1;
    localparam int          EE_DW       = 16;
    localparam int          EE_HB       = 5;
    localparam int          EE_CW       = EE_DW + EE_HB + 1;
    localparam int          PF_HP_BYTES = 4;
    localparam int          EE_W_BYTES  = 2;
    localparam int          PF_SEC_HP   = 128;
    localparam int          EE_SEC_W    = 2;
    localparam logic [PF_CW-1:0] PF_ERASED = {PF_CW{1'b1}};
    localparam logic [EE_CW-1:0] EE_ERASED = {EE_CW{1'b1}};

    // command codes
    localparam logic [7:0]  CMD_PGM_PF  = 8'h01;
    localparam logic [7:0]  CMD_ERS_PF  = 8'h02;
    localparam logic [7:0]  CMD_PGM_EE  = 8'h03;
    localparam logic [7:0]  CMD_ERS_EE  = 8'h04;

    // command execution times in bus cycles
    localparam int          PGM_CYC_DEF = 16;
    localparam int          ERS_CYC_DEF = 64;
    localparam int          CNT_W       = 16;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_APPLY} flmc_state_t;

endpackage

//--- design/flmc_ecc.sv
// flmc_ecc: single-error-correct, double-error-detect code of width DW.
// check bits are stored so that an all-ones (erased) codeword is valid.
`timescale 1ns/1ns
module flmc_ecc #(
    parameter int DW = 32,
    parameter int HB = 6
) (
    // encoder
    input  wire logic [DW-1:0] enc_data,
    output logic      [HB:0]   enc_chk,
    // decoder
    input  wire logic [DW-1:0] dec_data,
    input  wire logic [HB:0]   dec_chk,
    output logic      [DW-1:0] dec_fixed,
    output logic               dec_single,
    output logic               dec_double
);

    ////////////////////////////////////////////////////////////////////////
    // each data bit owns a non-power-of-two hamming position
    function automatic logic [HB-1:0] dpos(input int i);
        int              n;
        logic [HB-1:0]   r;
        n = 0;
        r = '0;
        for (int q = 3; q < (1 << HB); q++)
        begin
            if ((q & (q - 1)) != 0)
            begin
                if (n == i)
                    r = q[HB-1:0];
                n++;
            end
        end
        return r;
    endfunction

    function automatic logic [HB:0] code(input logic [DW-1:0] d);
        logic [HB-1:0] h;
        h = '0;
        for (int i = 0; i < DW; i++)
        begin
            if (d[i])
                h = h ^ dpos(i);
        end
        return {(^d) ^ (^h), h};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // inverted polarity keeps erased cells consistent with their check bits
    assign enc_chk = ~code(~enc_data);

    always_comb
    begin
        logic [HB-1:0] syn;
        logic          par;
        logic [HB:0]   rc;
        syn = '0;
        par = 1'b0;
        rc  = code(~dec_data);
        syn = rc[HB-1:0] ^ ~dec_chk[HB-1:0];
        par = (^(~dec_data)) ^ (^(~dec_chk));
        dec_fixed = dec_data;
        for (int i = 0; i < DW; i++)
        begin
            if (par && syn == dpos(i))
                dec_fixed[i] = ~dec_data[i];
        end
        dec_single = par;
        dec_double = !par && (syn != '0);
    end

endmodule

//--- design/flmc_core.sv
// flmc_core: program array, data eeprom and command sequencer of the
// nonvolatile memory controller. reads and commands come from a bus master
// on the same clock; all status shows on plain ports.
//
// Behaviour
// - one controller owns 128 KB program array and 512-byte eeprom.
// - byte and aligned word reads finish in one bus cycle.
// - erased bits read one, programmed bits read zero.
// - program array stays readable while eeprom command runs.
// - eeprom reads are not served while program array command runs.
// - forbidden concurrent access is reported as illegal access.
// - both arrays correct single and detect double bit faults.
// - program array programming uses aligned eight-byte phrases.
// - program reads fetch aligned half-phrase, correct one bit there.
// - command complete flag reads zero while a command executes.
// - writes to unmapped addresses refused with command error, unmapped reads give zero.
`timescale 1ns/1ns
module flmc_core
    import flmc_pkg::*;
#(
    parameter int PF_DEPTH = PF_BYTES / PF_HP_BYTES,
    parameter int EE_DEPTH = EE_BYTES / EE_W_BYTES,
    parameter int PGM_CYC  = PGM_CYC_DEF,
    parameter int ERS_CYC  = ERS_CYC_DEF
) (
    // clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RESETN,
    // read port
    input  wire logic              RD_EN,
    input  wire logic [ADDR_W-1:0] RD_ADDR,
    input  wire logic              RD_WORD,
    output logic      [15:0]       RD_DATA,
    output logic                   RD_VALID,
    // command object
    input  wire logic              CMD_LAUNCH,
    input  wire logic [7:0]        CMD_CODE,
    input  wire logic [ADDR_W-1:0] CMD_ADDR,
    input  wire logic [63:0]       CMD_DATA,
    // status
    output logic                   CMD_COMPLETE,
    output logic                   CMD_ERR,
    output logic                   ILLEGAL_ACC,
    output logic                   SGL_FAULT,
    output logic                   DBL_FAULT,
    input  wire logic              FLAG_CLR
);

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_q1_r;
    logic rst_n_r;

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
            {rst_n_r, rst_q1_r} <= 2'h0;
        else
            {rst_n_r, rst_q1_r} <= {rst_q1_r, 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////
    // storage and address decode
    // arrays sized
    logic [PF_CW-1:0] pmem [PF_DEPTH];
    logic [EE_CW-1:0] emem [EE_DEPTH];

    logic             rd_in_pf;
    logic             rd_in_ee;
    logic             cm_in_pf;
    logic             cm_in_ee;
    logic [14:0]      rd_pidx;
    logic [7:0]       rd_eidx;

    assign rd_in_pf = RD_ADDR[ADDR_W-1:PF_AW] == PF_TAG;
    assign rd_in_ee = RD_ADDR[ADDR_W-1:EE_AW] == EE_TAG;
    assign cm_in_pf = CMD_ADDR[ADDR_W-1:PF_AW] == PF_TAG;
    assign cm_in_ee = CMD_ADDR[ADDR_W-1:EE_AW] == EE_TAG;
    assign rd_pidx  = RD_ADDR[PF_AW-1:2];
    assign rd_eidx  = RD_ADDR[EE_AW-1:1];

    ////////////////////////////////////////////////////////////////////////
    // ecc: decode on read, encode on program
    flmc_state_t       st_r;
    logic [7:0]        code_r;
    logic [ADDR_W-1:0] addr_r;
    logic [63:0]       data_r;
    logic              tgt_pf_r;
    logic [CNT_W-1:0]  cnt_r;

    logic [PF_DW-1:0]  pf_fix;
    logic              pf_sgl;
    logic              pf_dbl;
    logic [EE_DW-1:0]  ee_fix;
    logic              ee_sgl;
    logic              ee_dbl;
    logic [PF_HB:0]    chk_hi;
    logic [PF_HB:0]    chk_lo;
    logic [EE_HB:0]    chk_ee;
    flmc_ecc #(.DW(PF_DW), .HB(PF_HB)) u_ecc_pf_hi (
        .enc_data   (data_r[63:32]),
        .enc_chk    (chk_hi),
        .dec_data   (pmem[rd_pidx][PF_CW-1:PF_HB+1]),
        .dec_chk    (pmem[rd_pidx][PF_HB:0]),
        .dec_fixed  (pf_fix),
        .dec_single (pf_sgl),
        .dec_double (pf_dbl)
    );

    flmc_ecc #(.DW(PF_DW), .HB(PF_HB)) u_ecc_pf_lo (
        .enc_data   (data_r[31:0]),
        .enc_chk    (chk_lo),
        .dec_data   ('0),
        .dec_chk    ('0),
        .dec_fixed  (),
        .dec_single (),
        .dec_double ()
    );

    flmc_ecc #(.DW(EE_DW), .HB(EE_HB)) u_ecc_ee (
        .enc_data   (data_r[15:0]),
        .enc_chk    (chk_ee),
        .dec_data   (emem[rd_eidx][EE_CW-1:EE_HB+1]),
        .dec_chk    (emem[rd_eidx][EE_HB:0]),
        .dec_fixed  (ee_fix),
        .dec_single (ee_sgl),
        .dec_double (ee_dbl)
    );

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    logic pf_busy;
    logic cmd_ok;

    assign pf_busy = (st_r != ST_IDLE) && tgt_pf_r;

    always_comb
    begin
        cmd_ok = 1'b0;
        case (CMD_CODE)
            CMD_PGM_PF: cmd_ok = cm_in_pf && CMD_ADDR[2:0] == 3'h0;
            CMD_ERS_PF: cmd_ok = cm_in_pf;
            CMD_PGM_EE: cmd_ok = cm_in_ee && !CMD_ADDR[0];
            CMD_ERS_EE: cmd_ok = cm_in_ee;
            default:    cmd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            st_r     <= ST_IDLE;
            code_r   <= 8'h00;
            addr_r   <= '0;
            data_r   <= 64'h0;
            tgt_pf_r <= 1'b0;
            cnt_r    <= '0;
        end
        else
        begin
            case (st_r)
                ST_IDLE:
                begin
                    if (CMD_LAUNCH && cmd_ok)
                    begin
                        st_r     <= ST_WAIT;
                        code_r   <= CMD_CODE;
                        addr_r   <= CMD_ADDR;
                        data_r   <= CMD_DATA;
                        tgt_pf_r <= cm_in_pf;
                        if (CMD_CODE == CMD_PGM_PF || CMD_CODE == CMD_PGM_EE)
                            cnt_r <= CNT_W'(PGM_CYC - 1);
                        else
                            cnt_r <= CNT_W'(ERS_CYC - 1);
                    end
                end
                ST_WAIT:
                begin
                    if (cnt_r == '0)
                        st_r <= ST_APPLY;
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                ST_APPLY:
                    st_r <= ST_IDLE;
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // array update; reset models a blank part, contents otherwise retained
    always_ff @(posedge REF_CLK or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            for (int i = 0; i < PF_DEPTH; i++)
                pmem[i] <= PF_ERASED;
            for (int i = 0; i < EE_DEPTH; i++)
                emem[i] <= EE_ERASED;
        end
        else if (st_r == ST_APPLY)
        begin
            case (code_r)
                CMD_PGM_PF:
                begin
                    pmem[{addr_r[PF_AW-1:3], 1'b0}] <= {data_r[63:32], chk_hi};
                    pmem[{addr_r[PF_AW-1:3], 1'b1}] <= {data_r[31:0], chk_lo};
                end
                CMD_ERS_PF:
                    for (int k = 0; k < PF_SEC_HP; k++)
                        pmem[{addr_r[PF_AW-1:9], 7'(k)}] <= PF_ERASED;
                CMD_PGM_EE:
                    emem[addr_r[EE_AW-1:1]] <= {data_r[15:0], chk_ee};
                CMD_ERS_EE:
                    for (int k = 0; k < EE_SEC_W; k++)
                        emem[{addr_r[EE_AW-1:2], 1'(k)}] <= EE_ERASED;
                default:
                    ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path
    logic        rd_illegal;
    logic [15:0] rd_nxt;
    logic [15:0] pw;

    // eeprom blocked during program array command
    // program array open during eeprom command
    assign rd_illegal = RD_EN && ((rd_in_pf && pf_busy) ||
                                  (rd_in_ee && st_r != ST_IDLE));
    assign pw = RD_ADDR[1] ? pf_fix[15:0] : pf_fix[31:16];

    always_comb
    begin
        rd_nxt = 16'h0000;
        // refused and unmapped reads give zero
        if (rd_in_pf && !rd_illegal)
            rd_nxt = RD_WORD ? pw : {8'h00, RD_ADDR[0] ? pw[7:0] : pw[15:8]};
        else if (rd_in_ee && !rd_illegal)
            rd_nxt = RD_WORD ? ee_fix : {8'h00, RD_ADDR[0] ? ee_fix[7:0] : ee_fix[15:8]};
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            RD_DATA  <= 16'h0000;
            RD_VALID <= 1'b0;
        end
        else
        begin
            RD_VALID <= RD_EN;
            if (RD_EN)
                RD_DATA <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status; a set in the clearing cycle wins
    logic rd_ok_pf;
    logic rd_ok_ee;

    assign rd_ok_pf = RD_EN && rd_in_pf && !rd_illegal;
    assign rd_ok_ee = RD_EN && rd_in_ee && !rd_illegal;

    always_ff @(posedge REF_CLK or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            CMD_ERR     <= 1'b0;
            ILLEGAL_ACC <= 1'b0;
            SGL_FAULT   <= 1'b0;
            DBL_FAULT   <= 1'b0;
        end
        else
        begin
            CMD_ERR <= (st_r == ST_IDLE && CMD_LAUNCH && !cmd_ok) || (CMD_ERR && !FLAG_CLR);
            ILLEGAL_ACC <= rd_illegal || (ILLEGAL_ACC && !FLAG_CLR);
            SGL_FAULT <= (rd_ok_pf && pf_sgl) || (rd_ok_ee && ee_sgl) || (SGL_FAULT && !FLAG_CLR);
            DBL_FAULT <= (rd_ok_pf && pf_dbl) || (rd_ok_ee && ee_dbl) || (DBL_FAULT && !FLAG_CLR);
        end
    end

    assign CMD_COMPLETE = st_r == ST_IDLE;

endmodule

//--- testbench/flmc_core_assertions.sv
// flmc_chk: port-level checker for flmc_core.
// assumes it is bound to flmc_core and sees only its ports.
`timescale 1ns/1ns
module flmc_chk
    import flmc_pkg::*;
#(
    parameter int PGM_CYC = PGM_CYC_DEF,
    parameter int ERS_CYC = ERS_CYC_DEF
) (
    // clock and reset
    input wire logic              REF_CLK,
    input wire logic              RESETN,
    // read port
    input wire logic              RD_EN,
    input wire logic [ADDR_W-1:0] RD_ADDR,
    input wire logic              RD_WORD,
    input wire logic [15:0]       RD_DATA,
    input wire logic              RD_VALID,
    // command and status
    input wire logic              CMD_LAUNCH,
    input wire logic [7:0]        CMD_CODE,
    input wire logic              CMD_COMPLETE,
    input wire logic              CMD_ERR,
    input wire logic              ILLEGAL_ACC,
    input wire logic              DBL_FAULT,
    input wire logic              FLAG_CLR
);
    logic [CNT_W-1:0] busy_cnt_r;
    logic             pgm_r;
    logic             ee_r;
    wire logic        rd_pf = RD_ADDR[23:17] == PF_TAG;
    wire logic        rd_ee = RD_ADDR[23:9] == EE_TAG;
    wire logic        go    = CMD_LAUNCH && CMD_COMPLETE;

    ////////////////////////////////////////////////////////////////////////
    // busy length counter; the kind of command decides the expected count
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
            busy_cnt_r <= '0;
        else if (CMD_COMPLETE)
            busy_cnt_r <= '0;
        else
            busy_cnt_r <= busy_cnt_r + 1'b1;
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            pgm_r <= 1'b0;
            ee_r  <= 1'b0;
        end
        else if (go)
        begin
            pgm_r <= CMD_CODE == CMD_PGM_PF || CMD_CODE == CMD_PGM_EE;
            ee_r  <= CMD_CODE == CMD_PGM_EE || CMD_CODE == CMD_ERS_EE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    read_answer_a: assert property (RD_EN |=> RD_VALID)
        else $error("read not answered");
    read_quiet_a: assert property (!RD_EN |=> !RD_VALID)
        else $error("spurious read valid");
    byte_upper_a: assert property (RD_EN && !RD_WORD |=> RD_DATA[15:8] == 8'h00)
        else $error("byte read upper half not zero");
    busy_launch_a: assert property (go |=> !CMD_COMPLETE || CMD_ERR)
        else $error("launch did not start");
    busy_length_a: assert property ($rose(CMD_COMPLETE) |->
        busy_cnt_r == (pgm_r ? PGM_CYC + 1 : ERS_CYC + 1)) else $error("busy length");
    ee_refused_a: assert property (RD_EN && rd_ee && !CMD_COMPLETE |=>
        ILLEGAL_ACC && RD_DATA == 16'h0000) else $error("eeprom read while busy");
    pf_refused_a: assert property (RD_EN && rd_pf && !CMD_COMPLETE && !ee_r |=>
        ILLEGAL_ACC) else $error("program read not flagged");
    pf_served_a: assert property (RD_EN && rd_pf && !CMD_COMPLETE && ee_r &&
        !ILLEGAL_ACC |=> !ILLEGAL_ACC) else $error("program read refused");
    unmapped_zero_a: assert property (RD_EN && !rd_pf && !rd_ee |=>
        RD_DATA == 16'h0000 && $stable(ILLEGAL_ACC)) else $error("unmapped read");
    dbl_on_read_a: assert property ($rose(DBL_FAULT) |-> RD_VALID)
        else $error("double fault without read");
    flags_clear_a: assert property (FLAG_CLR && !RD_EN && !CMD_LAUNCH |=>
        !ILLEGAL_ACC && !CMD_ERR) else $error("flags not cleared");

    cover property (go && CMD_CODE == CMD_PGM_PF);
    cover property (RD_EN && rd_ee && !CMD_COMPLETE);
    cover property ($rose(CMD_ERR));
endmodule

bind flmc_core flmc_chk #(.PGM_CYC(PGM_CYC), .ERS_CYC(ERS_CYC)) chk_i (
    .REF_CLK, .RESETN, .RD_EN, .RD_ADDR, .RD_WORD, .RD_DATA, .RD_VALID,
    .CMD_LAUNCH, .CMD_CODE, .CMD_COMPLETE, .CMD_ERR, .ILLEGAL_ACC,
    .DBL_FAULT, .FLAG_CLR
);

//--- testbench/flmc_master.sv
// flmc_master: bus master model issuing reads and commands.
// assumes tasks are called from the bench; one request at a time.
`timescale 1ns/1ns
module flmc_master
    import flmc_pkg::*;
(
    // clock
    input wire logic                REF_CLK,
    // read port
    output logic                    RD_EN,
    output logic [ADDR_W-1:0]       RD_ADDR,
    output logic                    RD_WORD,
    input wire logic [15:0]         RD_DATA,
    input wire logic                RD_VALID,
    // command object
    output logic                    CMD_LAUNCH,
    output logic [7:0]              CMD_CODE,
    output logic [ADDR_W-1:0]       CMD_ADDR,
    output logic [63:0]             CMD_DATA,
    input wire logic                CMD_COMPLETE
);
    time t_l;

    initial
    begin
        {RD_EN, RD_WORD, CMD_LAUNCH} = 3'h0;
        RD_ADDR = '0;
        CMD_CODE = '0;
        CMD_ADDR = '0;
        CMD_DATA = '0;
    end

    // word reads come from the caller with address bit 0 already cleared
    task automatic rd(logic [ADDR_W-1:0] a, logic w, output logic [15:0] d);
        @(posedge REF_CLK);
        RD_EN <= 1'b1;
        RD_ADDR <= a;
        RD_WORD <= w;
        @(posedge REF_CLK);
        RD_EN <= 1'b0;
        RD_ADDR <= ~a;
        RD_WORD <= ~w;
        #1;
        d = RD_VALID ? RD_DATA : 16'hxxxx;
    endtask

    // code, address and data held with the launch
    // no launch until the last command is done
    task automatic cmd(logic [7:0] c, logic [ADDR_W-1:0] a, logic [63:0] dt);
        while (CMD_COMPLETE !== 1'b1)
            @(posedge REF_CLK);
        @(posedge REF_CLK);
        CMD_LAUNCH <= 1'b1;
        CMD_CODE <= c;
        CMD_ADDR <= a;
        CMD_DATA <= dt;
        @(posedge REF_CLK);
        t_l = $time;
        CMD_LAUNCH <= 1'b0;
        CMD_CODE <= ~c;
        CMD_ADDR <= ~a;
        CMD_DATA <= ~dt;
    endtask

    // counts edges from the launch edge until complete shows again
    task automatic wait_done(output int n);
        do
        begin
            @(posedge REF_CLK);
            #1;
        end
        while (CMD_COMPLETE !== 1'b1 && $time < t_l + 8000);
        n = int'(($time - 1 - t_l) / 8);
    endtask
endmodule

//--- testbench/test_flmc_core.sv
// test_flmc_core: self-checking bench for flmc_core with a byte model.
// assumes flmc_master drives the bus and the checker is bound.
`timescale 1ns/1ns
module test_flmc_core;
    import flmc_pkg::*;
    localparam int          PGM = 5;
    localparam int          ERS = 9;
    localparam logic [23:0] PFB = 24'hfe0000;
    localparam logic [23:0] EEB = 24'h100000;
    logic REF_CLK = 1'b0;
    logic RESETN  = 1'b0;
    logic FLAG_CLR = 1'b0;
    logic RD_EN, RD_WORD, RD_VALID, CMD_LAUNCH, CMD_COMPLETE;
    logic CMD_ERR, ILLEGAL_ACC, SGL_FAULT, DBL_FAULT;
    logic [23:0] RD_ADDR, CMD_ADDR;
    logic [15:0] RD_DATA;
    logic [7:0]  CMD_CODE;
    logic [63:0] CMD_DATA;
    int          failures = 0;
    int          total_checks = 0;
    logic [31:0] seed = 32'h9b6e523e;
    logic [7:0]  mem [int];

    flmc_core #(.PGM_CYC(PGM), .ERS_CYC(ERS)) DUT (.REF_CLK, .RESETN, .RD_EN,
        .RD_ADDR, .RD_WORD, .RD_DATA, .RD_VALID, .CMD_LAUNCH, .CMD_CODE, .CMD_ADDR,
        .CMD_DATA, .CMD_COMPLETE, .CMD_ERR, .ILLEGAL_ACC, .SGL_FAULT, .DBL_FAULT,
        .FLAG_CLR);
    flmc_master bm (.REF_CLK, .RD_EN, .RD_ADDR, .RD_WORD, .RD_DATA, .RD_VALID,
        .CMD_LAUNCH, .CMD_CODE, .CMD_ADDR, .CMD_DATA, .CMD_COMPLETE);

    initial
        forever #4 REF_CLK = ~REF_CLK;

    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] mb(int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction

    task automatic upd(logic [7:0] c, int a, logic [63:0] d);
        for (int i = 0; i < 512; i++)
        begin
            if (c == CMD_PGM_PF && i < 8)
                mem[a + i] = d[63 - 8 * i -: 8];
            if (c == CMD_PGM_EE && i < 2)
                mem[a + i] = d[15 - 8 * i -: 8];
            if (c == CMD_ERS_EE && i < 4)
                mem.delete((a & ~3) + i);
            if (c == CMD_ERS_PF)
                mem.delete((a & ~511) + i);
        end
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic rdc(logic [23:0] a, logic w);
        logic [15:0] d;
        int          b;
        b = w ? int'(a) & ~1 : int'(a);
        bm.rd(24'(b), w, d);
        chk(d, w ? {mb(b), mb(b + 1)} : {8'h00, mb(b)}, "read");
    endtask

    task automatic st(logic [3:0] e);
        chk({CMD_ERR, ILLEGAL_ACC, SGL_FAULT, DBL_FAULT}, e, "flags");
    endtask

    task automatic prog(logic [7:0] c, logic [23:0] a, logic [63:0] d, int cyc);
        int n;
        bm.cmd(c, a, d);
        bm.wait_done(n);
        chk(n, cyc, "busy time");
        upd(c, a, d);
    endtask

    task automatic clr();
        @(posedge REF_CLK);
        FLAG_CLR <= 1'b1;
        @(posedge REF_CLK);
        FLAG_CLR <= 1'b0;
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6000) @(posedge REF_CLK);
        failures++;
        $display("wrong value at %0t: watchdog expired", $time);
        finish_test();
    end

    initial
    begin
        logic [23:0] a;
        logic [23:0] pa [$];
        logic [63:0] dt;
        logic [15:0] d;
        int          n;
        repeat (5) @(posedge REF_CLK);
        RESETN <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        chk(CMD_COMPLETE, 1, "idle");
        st(4'h0);
        rdc(24'h1001ff, 1'b0);
        for (int i = 0; i < 6; i++)
            rdc(i[0] ? EEB + (rnd() & 24'h1ff) : PFB + (rnd() & 24'h1ffff), i[1]);
        $display("test 1 erased reads done");
        for (int i = 0; i < 3; i++)
        begin
            a = i == 0 ? 24'hfffff8 : PFB + 24'h10000 + 24'(i << 12) + (rnd() & 24'hff8);
            pa.push_back(a);
            prog(CMD_PGM_PF, a, {rnd(), rnd()}, PGM + 1);
            for (int j = 0; j < 8; j++)
                rdc(a + j, j % 3 == 0);
        end
        $display("test 2 phrase program done");
        a = EEB + (rnd() & 24'h1fe);
        dt = {32'h0, rnd()};
        bm.cmd(CMD_PGM_EE, a, dt);
        rdc(pa[1], 1'b1);
        st(4'h0);
        bm.wait_done(n);
        chk(n, PGM + 1, "eeprom busy time");
        upd(CMD_PGM_EE, a, dt);
        rdc(a, 1'b1);
        rdc(a + 1, 1'b0);
        $display("test 3 eeprom program done");
        dt = {rnd(), rnd()};
        bm.cmd(CMD_PGM_PF, PFB + 24'h100, dt);
        bm.rd(a, 1'b1, d);
        chk(d, 0, "eeprom read while busy");
        st(4'h4);
        bm.rd(pa[2], 1'b1, d);
        chk(d, 0, "program read while busy");
        bm.wait_done(n);
        chk(n, PGM + 1, "program busy time");
        upd(CMD_PGM_PF, PFB + 24'h100, dt);
        clr();
        st(4'h0);
        $display("test 4 concurrent reads done");
        prog(CMD_ERS_EE, a, 64'h0, ERS + 1);
        prog(CMD_ERS_PF, pa[0], 64'h0, ERS + 1);
        rdc(a, 1'b1);
        rdc(pa[0], 1'b1);
        rdc(24'hfffdfe, 1'b1);
        rdc(PFB + 24'h104, 1'b1);
        $display("test 5 erase done");
        bm.cmd(CMD_PGM_PF, PFB + 24'h204, 64'h0);
        bm.wait_done(n);
        chk(n, 1, "refused launch");
        st(4'h8);
        clr();
        rdc(PFB + 24'h204, 1'b1);
        bm.rd(24'h200000, 1'b1, d);
        chk(d, 0, "unmapped read");
        st(4'h0);
        $display("test 6 refusals done");
        finish_test();
    end
endmodule
